// [log_framer.sv]
`timescale 1ns/1ps
`default_nettype none
module log_framer #(
    parameter int DEPTH = log_framer_pkg::DEPTH_DEF,
    parameter int FETCH_MAX = log_framer_pkg::FETCH_MAX_DEF,
    parameter int DROP = log_framer_pkg::DROP_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire log_framer_pkg::state_cmd_t log_state_command_i,
    input wire logic entry_valid_i,
    input wire log_framer_pkg::log_entry_t entry_i,
    input wire logic [31:0] sample_period_ms_i,
    input wire logic log_fetch_query_i,
    output logic [7:0] byte_o,
    output logic byte_valid_o,
    output logic byte_last_o,
    input wire logic byte_ready_i,
    output logic logging_o,
    output logic [$clog2(DEPTH+1)-1:0] stored_count_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] DROP_C = CW'(DROP);
    localparam logic [CW-1:0] FMAX_C = CW'(FETCH_MAX);

    // ==========================================================
    // helpers
    function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p,
                                             input logic [CW-1:0] k);
        logic [CW:0] s;
        s = (CW+1)'(p) + (CW+1)'(k);
        if (s >= (CW+1)'(DEPTH)) begin
            s = s - (CW+1)'(DEPTH);
        end
        return s[PW-1:0];
    endfunction

    function automatic logic [31:0] bsum(input logic [31:0] w);
        return 32'(w[7:0]) + 32'(w[15:8]) + 32'(w[23:16]) + 32'(w[31:24]);
    endfunction

    // most significant digit lands in the lowest byte
    function automatic logic [63:0] len_ascii(input logic [31:0] v);
        logic [63:0] a;
        logic [31:0] r;
        a = '0;
        r = v;
        for (int i = 0; i < log_framer_pkg::LEN_DIGITS; i++) begin
            a[8*(log_framer_pkg::LEN_DIGITS-1-i) +: 8] =
                log_framer_pkg::ASCII_ZERO + 8'(r % 10);
            r = r / 10;
        end
        return a;
    endfunction

    // ==========================================================
    // state
    log_framer_pkg::log_entry_t mem [DEPTH];
    log_framer_pkg::log_entry_t rd_data_ff;
    log_framer_pkg::log_entry_t rec_ff;
    log_framer_pkg::frame_state_t state_ff;
    logic [PW-1:0] rd_ptr_ff, wr_ptr_ff, rd_addr_ff, base_ff;
    logic [PW-1:0] nxt_rd_ptr, nxt_wr_ptr;
    logic [CW-1:0] count_ff, nxt_count, n_ff, left_ff, scan_ff;
    logic [31:0] csum_ff, seq_ff, per_ff;
    logic [63:0] len_ff;
    logic [4:0] pos_ff;
    logic [3:0] bidx_ff;
    logic abort_ff;
    logic do_write, do_drop, advance, done_acc, pop, clear;
    logic [8*log_framer_pkg::HDR_BYTES-1:0] hdr_vec;

    assign advance = !byte_valid_o || byte_ready_i;
    assign done_acc = (state_ff == log_framer_pkg::S_DONE) && byte_ready_i;
    assign pop = done_acc && !abort_ff;
    assign clear = log_state_command_i.valid &&
        !(log_state_command_i.value == log_framer_pkg::ST_REMOTE && logging_o);

    // ==========================================================
    // logging state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            logging_o <= 1'b0;
        end else if (log_state_command_i.valid) begin
            logging_o <= log_state_command_i.value ==
                log_framer_pkg::ST_REMOTE;
        end
    end

    // ==========================================================
    // store pointers and count
    always_comb begin
        nxt_rd_ptr = rd_ptr_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_count = count_ff;
        do_write = 1'b0;
        do_drop = 1'b0;
        if (clear) begin
            nxt_rd_ptr = '0;
            nxt_wr_ptr = '0;
            nxt_count = '0;
        end else begin
            if (pop) begin
                nxt_rd_ptr = ptr_add(rd_ptr_ff, n_ff);
                nxt_count = count_ff - n_ff;
            end
            if (entry_valid_i && logging_o) begin
                if (nxt_count < DEPTH_C) begin
                    do_write = 1'b1;
                end else if (state_ff == log_framer_pkg::S_IDLE) begin
                    do_drop = 1'b1;
                    do_write = 1'b1;
                    nxt_rd_ptr = ptr_add(nxt_rd_ptr, DROP_C);
                    nxt_count = nxt_count - DROP_C;
                end
                if (do_write) begin
                    nxt_wr_ptr = ptr_add(wr_ptr_ff, CW'(1));
                    nxt_count = nxt_count + CW'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ptr_ff <= '0;
            wr_ptr_ff <= '0;
            count_ff <= '0;
            stored_count_o <= '0;
        end else begin
            rd_ptr_ff <= nxt_rd_ptr;
            wr_ptr_ff <= nxt_wr_ptr;
            count_ff <= nxt_count;
            stored_count_o <= nxt_count;
        end
    end

    // ==========================================================
    // entry memory
    always_ff @(posedge clk_i) begin
        if (do_write) begin
            mem[wr_ptr_ff] <= entry_i;
            if (entry_i.entry_status_word[log_framer_pkg::BIT_CP]) begin
                mem[wr_ptr_ff].entry_status_word[log_framer_pkg::BIT_CV]
                    <= 1'b1;
            end
        end
        rd_data_ff <= mem[rd_addr_ff];
    end

    // ==========================================================
    // answer number
    always_ff @(posedge clk_i) begin
        if (rst_i || clear) begin
            seq_ff <= '0;
        end else if (pop && n_ff != '0) begin
            seq_ff <= (seq_ff == log_framer_pkg::SEQ_MAX) ? '0
                : seq_ff + 32'h0000_0001;
        end
    end

    // ==========================================================
    // framer
    // byte 0 of the header sits in the low bits
    assign hdr_vec = {32'(n_ff), per_ff,
        (n_ff == '0) ? 32'h0000_0000 : seq_ff,
        csum_ff, log_framer_pkg::RSV_BYTES, len_ff,
        log_framer_pkg::DIGITS_BYTE, log_framer_pkg::START_BYTE};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= log_framer_pkg::S_IDLE;
            byte_o <= '0;
            byte_valid_o <= 1'b0;
            byte_last_o <= 1'b0;
            rd_addr_ff <= '0;
            base_ff <= '0;
            n_ff <= '0;
            left_ff <= '0;
            scan_ff <= '0;
            csum_ff <= '0;
            per_ff <= '0;
            len_ff <= '0;
            pos_ff <= '0;
            bidx_ff <= '0;
            rec_ff <= '0;
            abort_ff <= 1'b0;
        end else begin
            if (advance) begin
                byte_valid_o <= 1'b0;
                byte_last_o <= 1'b0;
            end
            if (clear && state_ff != log_framer_pkg::S_IDLE) begin
                abort_ff <= 1'b1;
            end
            case (state_ff)
            log_framer_pkg::S_IDLE: begin
                if (log_fetch_query_i && logging_o
                    && !clear) begin
                    n_ff <= (count_ff > FMAX_C) ? FMAX_C
                        : count_ff;
                    per_ff <= (count_ff == '0) ? '0
                        : sample_period_ms_i;
                    csum_ff <= (count_ff == '0) ? '0 : bsum(seq_ff)
                        + bsum(sample_period_ms_i)
                        + bsum(32'((count_ff > FMAX_C) ? FMAX_C : count_ff));
                    rd_addr_ff <= rd_ptr_ff;
                    base_ff <= rd_ptr_ff;
                    scan_ff <= '0;
                    abort_ff <= 1'b0;
                    state_ff <= log_framer_pkg::S_SCAN;
                end
            end
            log_framer_pkg::S_SCAN: begin
                // pre-pass sums the records before the header goes out
                scan_ff <= scan_ff + CW'(1);
                rd_addr_ff <= ptr_add(rd_addr_ff, CW'(1));
                if (scan_ff != '0) begin
                    csum_ff <= csum_ff + bsum(rd_data_ff.entry_status_word)
                        + bsum(rd_data_ff.entry_voltage_mv)
                        + bsum(rd_data_ff.entry_current_ma);
                end
                if (scan_ff == n_ff) begin
                    len_ff <= len_ascii(32'(log_framer_pkg::LEN_BASE)
                        + 32'(n_ff)
                        * 32'(log_framer_pkg::REC_BYTES));
                    rd_addr_ff <= base_ff;
                    pos_ff <= '0;
                    state_ff <= log_framer_pkg::S_HEAD;
                end
            end
            log_framer_pkg::S_HEAD: begin
                if (advance) begin
                    byte_o <= hdr_vec[8*pos_ff +: 8];
                    byte_valid_o <= 1'b1;
                    pos_ff <= pos_ff + 5'h1;
                    if (pos_ff == 5'(log_framer_pkg::HDR_BYTES - 1)) begin
                        left_ff <= n_ff;
                        bidx_ff <= '0;
                        rec_ff <= rd_data_ff;
                        rd_addr_ff <= ptr_add(rd_addr_ff, CW'(1));
                        state_ff <= (n_ff == '0) ? log_framer_pkg::S_TERM
                            : log_framer_pkg::S_REC;
                    end
                end
            end
            log_framer_pkg::S_REC: begin
                if (advance) begin
                    // status, voltage, current, each low byte first
                    byte_o <= rec_ff[8*bidx_ff +: 8];
                    byte_valid_o <= 1'b1;
                    bidx_ff <= bidx_ff + 4'h1;
                    if (bidx_ff == 4'(log_framer_pkg::REC_BYTES - 1)) begin
                        bidx_ff <= '0;
                        left_ff <= left_ff - CW'(1);
                        rec_ff <= rd_data_ff;
                        rd_addr_ff <= ptr_add(rd_addr_ff, CW'(1));
                        if (left_ff == CW'(1)) begin
                            state_ff <= log_framer_pkg::S_TERM;
                        end
                    end
                end
            end
            log_framer_pkg::S_TERM: begin
                if (advance) begin
                    byte_o <= log_framer_pkg::TERM_BYTE;
                    byte_valid_o <= 1'b1;
                    byte_last_o <= 1'b1;
                    state_ff <= log_framer_pkg::S_DONE;
                end
            end
            log_framer_pkg::S_DONE: begin
                if (byte_ready_i) begin
                    state_ff <= log_framer_pkg::S_IDLE;
                end
            end
            default: state_ff <= log_framer_pkg::S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // checks
    property p_count_max;
        @(posedge clk_i) disable iff (rst_i) count_ff <= DEPTH_C;
    endproperty
    a_count_max: assert property (p_count_max)
        else $error("store count above depth");
    property p_n_max;
        @(posedge clk_i) disable iff (rst_i) n_ff <= FMAX_C;
    endproperty
    a_n_max: assert property (p_n_max)
        else $error("frame carries too many entries");
    property p_stop_clears;
        @(posedge clk_i) disable iff (rst_i)
        log_state_command_i.valid &&
        log_state_command_i.value == log_framer_pkg::ST_STOP
        |=> count_ff == '0 && !logging_o && seq_ff == '0;
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("stop did not clear the store");
    property p_no_frame_stopped;
        @(posedge clk_i) disable iff (rst_i)
        state_ff == log_framer_pkg::S_IDLE && !logging_o
        |=> state_ff == log_framer_pkg::S_IDLE;
    endproperty
    a_no_frame_stopped: assert property (p_no_frame_stopped)
        else $error("frame started while stopped");
    property p_drop;
        @(posedge clk_i) disable iff (rst_i)
        do_drop |=> count_ff == DEPTH_C - DROP_C + CW'(1);
    endproperty
    a_drop: assert property (p_drop)
        else $error("overflow drop count wrong");
    property p_start_byte;
        @(posedge clk_i) disable iff (rst_i)
        state_ff == log_framer_pkg::S_HEAD && pos_ff == 5'h0 && advance
        |=> byte_valid_o && byte_o == log_framer_pkg::START_BYTE
        ##1 (byte_o == log_framer_pkg::DIGITS_BYTE || !$past(byte_ready_i));
    endproperty
    a_start_byte: assert property (p_start_byte)
        else $error("bad frame start");
    property p_term_last;
        @(posedge clk_i) disable iff (rst_i)
        byte_last_o |-> byte_valid_o && byte_o == log_framer_pkg::TERM_BYTE;
    endproperty
    a_term_last: assert property (p_term_last)
        else $error("last byte is not the terminator");
    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte changed while stalled");
    property p_seq_wrap;
        @(posedge clk_i) disable iff (rst_i)
        pop && n_ff != '0 && seq_ff == log_framer_pkg::SEQ_MAX && !clear
        |=> seq_ff == '0;
    endproperty
    a_seq_wrap: assert property (p_seq_wrap)
        else $error("answer number did not wrap");
    c_full_frame: cover property (@(posedge clk_i) pop && n_ff != '0);
    c_empty_frame: cover property (@(posedge clk_i) pop && n_ff == '0);
    c_drop: cover property (@(posedge clk_i) do_drop);
endmodule
`default_nettype wire

// [log_framer_pkg.sv]
// Functional notes
// - store holds up to 8000 entries while logging runs
// - one answer carries at most 1000 entries as a binary block
// - state 2 starts remote logging; state 1 selects removable storage
// - entries sent in an answer leave the store
// - no answers while stopped; repeated fetches allowed while running
// - a write to a full store first drops the oldest 1000 entries; while a frame is being sent the new entry is discarded instead
// - state 0 stops logging and clears the store
// - frame opens with byte 0x23
// - second byte is ASCII eight, the length digit count
// - eight zero-padded ASCII digits give bytes up to the terminator
// - two zero reserved bytes follow the length
// - 4-byte byte sum of the payload after it, low byte first
// - answer number counts from zero, wraps past 1999999999 or restart
// - 4-byte sample period in milliseconds, low byte first
// - 4-byte record count, low byte first
// - records go oldest first, 12 bytes each
// - record is status, voltage, current with no separators
// - status word goes low byte first
// - voltage is unsigned millivolts, low byte first
// - current is unsigned milliamperes, low byte first
// - frame ends with byte 0x0a
// - empty store gives a frame whose payload bytes are all zero
// - status bit 8 is forced whenever bit 9 is set
`default_nettype none
package log_framer_pkg;
    // ==========================================================
    // sizes and codes
    localparam int DEPTH_DEF = 8000;
    localparam int FETCH_MAX_DEF = 1000;
    localparam int DROP_DEF = 1000;
    localparam logic [1:0] ST_STOP = 2'h0;
    localparam logic [1:0] ST_STORAGE = 2'h1;
    localparam logic [1:0] ST_REMOTE = 2'h2;
    localparam logic [7:0] START_BYTE = 8'h23;
    localparam logic [7:0] DIGITS_BYTE = 8'h38;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] TERM_BYTE = 8'h0a;
    localparam logic [15:0] RSV_BYTES = 16'h0000;
    localparam logic [31:0] SEQ_MAX = 32'h7735_93ff;
    localparam int LEN_DIGITS = 8;
    localparam int HDR_BYTES = 28;
    localparam int LEN_BASE = 18;
    localparam int REC_BYTES = 12;
    localparam int BIT_CV = 8;
    localparam int BIT_CP = 9;

    // ==========================================================
    // types
    typedef struct packed {
        logic [31:0] entry_current_ma;
        logic [31:0] entry_voltage_mv;
        logic [31:0] entry_status_word;
    } log_entry_t;

    typedef struct packed {
        logic valid;
        logic [1:0] value;
    } state_cmd_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_SCAN = 3'h1,
        S_HEAD = 3'h2,
        S_REC = 3'h3,
        S_TERM = 3'h4,
        S_DONE = 3'h5
    } frame_state_t;
endpackage
`default_nettype wire

// [log_sink_model.sv]
`timescale 1ns/1ps
`default_nettype none
module log_sink_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_valid_i,
    input wire logic byte_last_i,
    output logic byte_ready_o
);
    logic [7:0] rx_q[$];
    int frames;

    initial begin
        byte_ready_o = 1'b0;
        frames = 0;
    end

    // ==========================================================
    // remote controller: takes one byte per handshake
    // slow mode stalls every other cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            byte_ready_o <= #1 1'b0;
        end else begin
            if (byte_valid_i && byte_ready_o) begin
                rx_q.push_back(byte_i);
                if (byte_last_i) begin
                    frames = frames + 1;
                end
            end
            byte_ready_o <= #1 !slow_i || !byte_ready_o;
        end
    end
endmodule
`default_nettype wire

// [measurement_log_block_framer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module measurement_log_block_framer_tb;
    localparam int DEPTH = 16;
    localparam int FMAX = 4;
    localparam int DROP = 4;
    logic clk_i, rst_i, entry_valid_i, log_fetch_query_i, slow, running;
    log_framer_pkg::state_cmd_t log_state_command_i;
    log_framer_pkg::log_entry_t entry_i;
    logic [31:0] sample_period_ms_i, seq;
    logic [7:0] byte_o;
    logic byte_valid_o, byte_last_o, byte_ready_i, logging_o;
    logic [4:0] stored_count_o;
    log_framer_pkg::log_entry_t model_q[$];
    logic [7:0] exp_q[$];
    logic [7:0] pay_q[$];
    int miscompares, compares;

    log_framer #(.DEPTH(DEPTH), .FETCH_MAX(FMAX), .DROP(DROP)) uut (
        .clk_i(clk_i), .rst_i(rst_i),
        .log_state_command_i(log_state_command_i),
        .entry_valid_i(entry_valid_i), .entry_i(entry_i),
        .sample_period_ms_i(sample_period_ms_i),
        .log_fetch_query_i(log_fetch_query_i), .byte_o(byte_o),
        .byte_valid_o(byte_valid_o), .byte_last_o(byte_last_o),
        .byte_ready_i(byte_ready_i), .logging_o(logging_o),
        .stored_count_o(stored_count_o));

    log_sink_model sink (
        .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .byte_i(byte_o),
        .byte_valid_i(byte_valid_o), .byte_last_i(byte_last_o),
        .byte_ready_o(byte_ready_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic add32(input logic [31:0] v);
        for (int k = 0; k < 4; k++) pay_q.push_back(v[8*k +: 8]);
    endtask

    task automatic send_cmd(input logic [1:0] v);
        @(posedge clk_i);
        #1;
        log_state_command_i = '{valid: 1'b1, value: v};
        @(posedge clk_i);
        #1;
        log_state_command_i.valid = 1'b0;
        if (!(v == 2'h2 && running)) begin
            model_q.delete();
            seq = 32'h0000_0000;
        end
        running = (v == 2'h2);
        chk("logging", {31'h0, running}, {31'h0, logging_o});
        chk("count", model_q.size(), {27'h0, stored_count_o});
    endtask

    task automatic put_entry(input logic [31:0] st, vm, cm);
        log_framer_pkg::log_entry_t e;
        e = {cm, vm, st};
        @(posedge clk_i);
        #1;
        entry_i = e;
        entry_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        entry_valid_i = 1'b0;
        if (st[9]) e.entry_status_word[8] = 1'b1;
        if (model_q.size() == DEPTH) begin
            for (int k = 0; k < DROP; k++) model_q.delete(0);
        end
        model_q.push_back(e);
        chk("count", model_q.size(), {27'h0, stored_count_o});
    endtask

    task automatic fetch(input bit refused);
        int n, f0, wait_n;
        logic [31:0] len, sum;
        n = (model_q.size() < FMAX) ? model_q.size() : FMAX;
        if (refused) n = 0;
        pay_q.delete();
        exp_q.delete();
        add32(n > 0 ? seq : 32'h0000_0000);
        add32(n > 0 ? sample_period_ms_i : 32'h0000_0000);
        add32(n);
        for (int k = 0; k < n; k++) begin
            add32(model_q[k].entry_status_word);
            add32(model_q[k].entry_voltage_mv);
            add32(model_q[k].entry_current_ma);
        end
        sum = 32'h0000_0000;
        foreach (pay_q[k]) sum += 32'(pay_q[k]);
        len = 18 + 12 * n;
        exp_q = {8'h23, 8'h38};
        for (int k = 7; k >= 0; k--) begin
            exp_q.push_back(8'h30 + 8'((len / (10 ** k)) % 10));
        end
        exp_q = {exp_q, 8'h00, 8'h00, sum[7:0], sum[15:8], sum[23:16],
                 sum[31:24], pay_q, 8'h0a};
        sink.rx_q.delete();
        f0 = sink.frames;
        @(posedge clk_i);
        #1;
        log_fetch_query_i = 1'b1;
        @(posedge clk_i);
        #1;
        log_fetch_query_i = 1'b0;
        wait_n = 0;
        while (sink.frames == f0 && wait_n < (refused ? 60 : 3000)) begin
            @(posedge clk_i);
            #1;
            wait_n++;
        end
        chk("frames", f0 + (refused ? 0 : 1), sink.frames);
        if (refused) return;
        chk("frame size", exp_q.size(), sink.rx_q.size());
        foreach (exp_q[k]) begin
            if (k < sink.rx_q.size()) begin
                chk("frame byte", 32'(exp_q[k]),
                    32'(sink.rx_q[k]));
            end
        end
        repeat (2) @(posedge clk_i);
        #1;
        for (int k = 0; k < n; k++) model_q.delete(0);
        if (n > 0) seq++;
        chk("count", model_q.size(), {27'h0, stored_count_o});
    endtask

    // ==========================================================
    // scenarios
    task automatic t_empty();
        send_cmd(2'h2);
        fetch(1'b0);
        $display("test empty frame done");
    endtask

    task automatic t_records();
        slow = 1'b1;
        sample_period_ms_i = 32'h0000_ea60;
        put_entry(32'h0000_0208, 32'h0000_619c, 32'h0000_0000);
        put_entry(32'h8421_0118, 32'h0102_0304, 32'hfedc_ba98);
        put_entry(32'h0000_0010, 32'h0000_0000, 32'h0000_01e9);
        fetch(1'b0);
        for (int k = 0; k < 6; k++) begin
            put_entry(32'h0000_0100 + k, 32'h1000 * k,
                      32'h0000_0007 + k);
        end
        fetch(1'b0);
        fetch(1'b0);
        slow = 1'b0;
        $display("test record frames done");
    endtask

    task automatic t_overflow();
        for (int k = 0; k <= DEPTH; k++) begin
            put_entry(32'h0000_0000 + k, 32'h0000_0100 + k,
                      32'h55 + k);
        end
        chk("count after drop", DEPTH - DROP + 1,
            {27'h0, stored_count_o});
        for (int k = 0; k < 4; k++) fetch(1'b0);
        $display("test overflow done");
    endtask

    task automatic t_stop();
        put_entry(32'h0000_0008, 32'h0000_1234, 32'h0000_0042);
        send_cmd(2'h0);
        fetch(1'b1);
        send_cmd(2'h2);
        put_entry(32'h0000_0200, 32'h0000_0001, 32'h0000_0002);
        send_cmd(2'h2);
        fetch(1'b0);
        send_cmd(2'h1);
        fetch(1'b1);
        send_cmd(2'h2);
        put_entry(32'h0000_0008, 32'h0000_0003, 32'h0000_0004);
        send_cmd(2'h3);
        fetch(1'b1);
        $display("test stop and restart done");
    endtask

    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        rst_i = 1'b1;
        entry_valid_i = 1'b0;
        log_fetch_query_i = 1'b0;
        log_state_command_i = '{valid: 1'b0, value: 2'h0};
        entry_i = '0;
        sample_period_ms_i = 32'h0000_03e8;
        slow = 1'b0;
        running = 1'b0;
        seq = 32'h0000_0000;
        miscompares = 0;
        compares = 0;
        repeat (3) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        t_empty();
        t_records();
        t_overflow();
        t_stop();
        report_and_stop();
    end

    initial begin
        #200000;
        miscompares++;
        $display("[ERR] watchdog expected end seen hang");
        report_and_stop();
    end
endmodule
`default_nettype wire
